// ---- rtl/mprot_cfg.svh ----
`ifndef MPROT_CFG_SVH
`define MPROT_CFG_SVH

// Control-status register numbers of the protection unit
`define MPROT_CSR_ADDR_W 12
`define MPROT_CSR_CONFIG 12'h3A0
`define MPROT_CSR_BOUND0 12'h3B0
`define MPROT_CSR_BOUND1 12'h3B1
`define MPROT_CSR_BOUND2 12'h3B2
`define MPROT_CSR_BOUND3 12'h3B3

// Number of entries and field layout of one configuration byte
`define MPROT_ENTRIES 4
`define MPROT_CFG_BYTE_W 8
`define MPROT_CFG_LOCK_BIT 7
`define MPROT_CFG_MODE_HI 4
`define MPROT_CFG_MODE_LO 3
`define MPROT_CFG_EXEC_BIT 2
`define MPROT_CFG_WRITE_BIT 1
`define MPROT_CFG_READ_BIT 0
`define MPROT_CFG_PERM_HI 2

// Bits 6:5 are reserved and always read as zero
`define MPROT_CFG_WRITABLE_MASK 8'h9F

// Bound registers hold address bits 33:2; the top two take no part in matching
`define MPROT_BOUND_W 32
`define MPROT_BOUND_USED_W 30

// Reset values
`define MPROT_CFG_BYTE_RESET 8'h00
`define MPROT_BOUND_RESET 32'h0000_0000
`define MPROT_RDATA_RESET 32'h0000_0000

`endif

// ---- rtl/mprot_pkg.sv ----
package mprot_pkg;
    `include "mprot_cfg.svh"

    // Address matching mode held in bits 4:3 of each configuration byte
    typedef enum logic [1:0] {
        MODE_OFF = 2'h0,  // Entry disabled
        MODE_TOP = 2'h1,  // Top of range, lower bound from previous entry
        MODE_WORD = 2'h2,  // Single four-byte word
        MODE_POW2 = 2'h3  // Naturally aligned power-of-two region
    } region_mode_t;

    // One-hot kind of access; each code lines up with its permission bit
    typedef enum logic [2:0] {
        ACC_READ = 3'h1,  // Load
        ACC_WRITE = 3'h2,  // Store
        ACC_EXEC = 3'h4  // Instruction fetch
    } access_kind_t;

    // Whole state of the protection unit
    typedef struct packed {
        logic [`MPROT_ENTRIES-1:0][`MPROT_CFG_BYTE_W-1:0] cfg;  // Configuration bytes
        logic [`MPROT_ENTRIES-1:0][`MPROT_BOUND_W-1:0] bound;  // Bound registers
        logic [`MPROT_BOUND_W-1:0] csr_rdata;  // Read answer
        logic csr_ack;  // CSR answer strobe
        logic csr_err;  // CSR access refused
        logic chk_done;  // Check answer strobe
        logic chk_allow;  // Access permitted
        logic chk_matched;  // Some enabled entry matched
        logic [1:0] chk_entry;  // Index of the deciding entry
        logic sys_exc;  // Exception pulse toward the core
    } unit_state_t;
endpackage

// ---- rtl/mprot_region_match.sv ----
`timescale 1ns/10ps
`default_nettype none

// Address match of one protection entry, purely combinational
module mprot_region_match
    import mprot_pkg::*;
(
    input wire region_mode_t mode,  // Matching mode of this entry
    input wire logic [`MPROT_BOUND_USED_W-1:0] bound_self,  // Own bound, word units
    input wire logic [`MPROT_BOUND_USED_W-1:0] bound_prev,  // Previous bound, word units
    input wire logic [`MPROT_BOUND_USED_W-1:0] word_addr,  // Access address bits 31:2
    output logic hit  // Access falls in this region
);

    logic [`MPROT_BOUND_USED_W-1:0] pow2_mask;  // Low word bits covered by the region

    // Trailing ones plus the next zero give the span: x ^ (x+1)
    always_comb begin
        pow2_mask = bound_self ^ (bound_self + `MPROT_BOUND_USED_W'(1));
    end

    // Mode select; word granularity resolves regions down to four bytes
    always_comb begin
        unique case (mode)
            MODE_OFF: begin
                hit = 1'b0;
            end
            MODE_TOP: begin
                hit = (word_addr >= bound_prev) && (word_addr < bound_self);
            end
            MODE_WORD: begin
                hit = (word_addr == bound_self);
            end
            MODE_POW2: begin
                hit = ((word_addr ^ bound_self) & ~pow2_mask) == '0;
            end
        endcase
    end

endmodule

`default_nettype wire

// ---- rtl/physical_memory_protect_unit.sv ----
`timescale 1ns/10ps
`default_nettype none

module physical_memory_protect_unit
    import mprot_pkg::*;
(
    input wire logic clock,  // Core clock, 100 MHz
    input wire logic rst,  // Asynchronous reset, active high
    input wire logic ce,  // Clock enable, freezes all state when low
    input wire logic csr_valid,  // CSR access request
    input wire logic csr_write,  // Request writes (else read only)
    input wire logic [`MPROT_CSR_ADDR_W-1:0] csr_addr,  // CSR number
    input wire logic [`MPROT_BOUND_W-1:0] csr_wdata,  // Write data
    input wire logic csr_machine,  // Requester runs in machine mode
    output logic [`MPROT_BOUND_W-1:0] csr_rdata,  // Read data
    output logic csr_ack,  // Answer strobe, one cycle
    output logic csr_err,  // Access refused or unmapped
    input wire logic chk_valid,  // Memory access to check
    input wire logic [31:0] chk_addr,  // Physical byte address
    input wire access_kind_t chk_kind,  // Load, store or fetch
    input wire logic chk_machine,  // Access made in machine mode
    output logic chk_done,  // Check answer strobe, one cycle
    output logic chk_allow,  // Access may complete
    output logic chk_matched,  // An enabled entry matched
    output logic [1:0] chk_entry,  // Deciding entry index
    output logic system_exception  // Violation pulse toward the core
);

    // Reset image of the whole state
    localparam unit_state_t STATE_RESET = '{
        cfg: {`MPROT_ENTRIES{`MPROT_CFG_BYTE_RESET}},
        bound: {`MPROT_ENTRIES{`MPROT_BOUND_RESET}},
        csr_rdata: `MPROT_RDATA_RESET,
        default: '0
    };

    unit_state_t st_q;  // Registered state
    unit_state_t st_d;  // Next state

    logic [`MPROT_ENTRIES-1:0] entry_hit;  // Per-entry address match
    logic [`MPROT_ENTRIES-1:0] entry_locked;  // Per-entry lock bit
    logic [`MPROT_ENTRIES-1:0] bound_frozen;  // Bound write-protected
    region_mode_t entry_mode [`MPROT_ENTRIES];  // Per-entry mode field
    logic [`MPROT_BOUND_USED_W-1:0] access_word;  // Access address in word units

    // Physical addresses are 32 bits wide, so bits 33:32 never take part
    assign access_word = chk_addr[31:2];

    // Per-entry decode, lock propagation and address matching
    for (genvar i = 0; i < `MPROT_ENTRIES; i++) begin : g_entry
        logic [`MPROT_BOUND_USED_W-1:0] prev_bound;  // Lower bound for range mode

        assign entry_mode[i] = region_mode_t'(
            st_q.cfg[i][`MPROT_CFG_MODE_HI:`MPROT_CFG_MODE_LO]);
        assign entry_locked[i] = st_q.cfg[i][`MPROT_CFG_LOCK_BIT];

        // Entry 0 counts from address zero in range mode
        if (i == 0) begin : g_first
            assign prev_bound = '0;
        end else begin : g_next
            assign prev_bound = st_q.bound[i-1][`MPROT_BOUND_USED_W-1:0];
        end

        // A bound serving as the floor of a locked range entry is frozen too,
        // otherwise software could slide the lower edge of a locked region
        if (i == `MPROT_ENTRIES - 1) begin : g_last
            assign bound_frozen[i] = entry_locked[i];
        end else begin : g_inner
            assign bound_frozen[i] = entry_locked[i] ||
                (st_q.cfg[i+1][`MPROT_CFG_LOCK_BIT] &&
                 st_q.cfg[i+1][`MPROT_CFG_MODE_HI:`MPROT_CFG_MODE_LO] == MODE_TOP);
        end

        mprot_region_match u_match (
            .mode(entry_mode[i]),
            .bound_self(st_q.bound[i][`MPROT_BOUND_USED_W-1:0]),
            .bound_prev(prev_bound),
            .word_addr(access_word),
            .hit(entry_hit[i])
        );
    end

    // Next-state logic: CSR port and access check
    always_comb begin
        logic found;  // A matching entry was already taken
        logic [1:0] idx;  // Bound register index from CSR number
        logic [`MPROT_CFG_PERM_HI:0] perm;  // Permissions of the deciding entry
        logic enforce;  // Deciding entry applies in this privilege
        logic allow;  // Verdict

        found = 1'b0;
        idx = csr_addr[1:0];
        perm = '0;
        enforce = 1'b0;
        allow = 1'b0;

        st_d = st_q;
        // Strobes last exactly one cycle
        st_d.csr_ack = 1'b0;
        st_d.csr_err = 1'b0;
        st_d.chk_done = 1'b0;
        st_d.sys_exc = 1'b0;

        // CSR access; answer comes one cycle after the request
        if (csr_valid) begin
            st_d.csr_ack = 1'b1;
            st_d.csr_rdata = `MPROT_RDATA_RESET;
            if (!csr_machine) begin
                // Only machine mode may see or change protection state
                st_d.csr_err = 1'b1;
            end else if (csr_addr == `MPROT_CSR_CONFIG) begin
                st_d.csr_rdata = st_q.cfg;
                if (csr_write) begin
                    // Each byte lane updates only while its entry is unlocked
                    for (int i = 0; i < `MPROT_ENTRIES; i++) begin
                        if (!entry_locked[i]) begin
                            st_d.cfg[i] = csr_wdata[i*`MPROT_CFG_BYTE_W +: `MPROT_CFG_BYTE_W]
                                & `MPROT_CFG_WRITABLE_MASK;
                        end
                    end
                end
            end else if (csr_addr[`MPROT_CSR_ADDR_W-1:2] ==
                         `MPROT_CSR_BOUND0 >> 2) begin
                // All 32 bits are stored; matching uses only the low 30
                st_d.csr_rdata = st_q.bound[idx];
                if (csr_write && !bound_frozen[idx]) begin
                    st_d.bound[idx] = csr_wdata;
                end
            end else begin
                // Unmapped CSR number answers with an error and zero data
                st_d.csr_err = 1'b1;
            end
        end

        // Access check: the lowest-numbered enabled match decides
        if (chk_valid) begin
            st_d.chk_done = 1'b1;
            st_d.chk_entry = 2'h0;
            for (int i = 0; i < `MPROT_ENTRIES; i++) begin
                if (!found && entry_hit[i]) begin
                    found = 1'b1;
                    st_d.chk_entry = 2'(i);
                    perm = st_q.cfg[i][`MPROT_CFG_PERM_HI:0];
                    enforce = !chk_machine || entry_locked[i];
                end
            end
            if (found) begin
                // One-hot kind lines up with the read, write and execute bits
                allow = !enforce || ((perm & chk_kind) != '0);
            end else begin
                // Unmatched: machine passes, user is refused
                allow = chk_machine;
            end
            st_d.chk_matched = found;
            st_d.chk_allow = allow;
            st_d.sys_exc = !allow;
        end
    end

    // State register; the clock enable holds everything still
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_q <= STATE_RESET;
        end else if (ce) begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state register
    assign csr_rdata = st_q.csr_rdata;
    assign csr_ack = st_q.csr_ack;
    assign csr_err = st_q.csr_err;
    assign chk_done = st_q.chk_done;
    assign chk_allow = st_q.chk_allow;
    assign chk_matched = st_q.chk_matched;
    assign chk_entry = st_q.chk_entry;
    assign system_exception = st_q.sys_exc;

endmodule

`default_nettype wire

// ---- testbench/pmp_check_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
// Port-level watch on the protection unit
module pmp_check (
    input wire logic clock, // Clock
    input wire logic rst, // Reset
    input wire logic ce, // Enable
    input wire logic csr_valid, // CSR request
    input wire logic csr_machine, // CSR privilege
    input wire logic [31:0] csr_rdata, // Read data
    input wire logic csr_ack, // CSR answer
    input wire logic csr_err, // CSR refusal
    input wire logic chk_valid, // Check request
    input wire logic chk_machine, // Check privilege
    input wire logic chk_done, // Check answer
    input wire logic chk_allow, // Permit
    input wire logic chk_matched, // Hit
    input wire logic [1:0] chk_entry, // Deciding entry
    input wire logic system_exception // Violation
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Answers follow each taken request by one edge
    property p_ack; ce && csr_valid |=> csr_ack; endproperty
    a_ack: assert property (p_ack) else $error("csr answer missing");
    property p_priv; ce && csr_valid && !csr_machine |=> csr_err && csr_rdata == 32'h0; endproperty
    a_priv: assert property (p_priv) else $error("user csr access not refused");
    property p_done; ce && chk_valid |=> chk_done; endproperty
    a_done: assert property (p_done) else $error("check answer missing");
    property p_exc; chk_done |-> system_exception == !chk_allow; endproperty
    a_exc: assert property (p_exc) else $error("exception disagrees with verdict");
    // Strobes must drop when nothing was taken, else one access raises two traps
    property p_quiet; ce && !chk_valid |=> !chk_done && !system_exception; endproperty
    a_quiet: assert property (p_quiet) else $error("stray check strobe");
    property p_user; ce && chk_valid && !chk_machine |=> chk_matched || !chk_allow; endproperty
    a_user: assert property (p_user) else $error("unmatched user access let through");
    property p_mach; ce && chk_valid && chk_machine |=> chk_matched || chk_allow; endproperty
    a_mach: assert property (p_mach) else $error("unmatched machine access refused");
    property p_none; chk_done && !chk_matched |-> chk_entry == 2'h0; endproperty
    a_none: assert property (p_none) else $error("entry index without a match");
    c_exc: cover property (system_exception);
    c_err: cover property (csr_ack && csr_err);
    c_hit: cover property (chk_done && chk_allow && chk_matched);
endmodule
`default_nettype wire

// ---- testbench/core_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// Core side: issues CSR instructions and memory accesses
module core_model
    import mprot_pkg::*;
(
    input wire logic clock, // Core clock
    output logic csr_valid, // CSR request
    output logic csr_write, // Write
    output logic [11:0] csr_addr, // CSR number
    output logic [31:0] csr_wdata, // Write data
    output logic csr_machine, // Privilege
    output logic chk_valid, // Access request
    output logic [31:0] chk_addr, // Byte address
    output var access_kind_t chk_kind, // Access kind
    output logic chk_machine // Privilege
);
    // Idle at time zero
    initial begin
        {csr_valid, csr_write, csr_addr, csr_wdata, csr_machine} = '0;
        {chk_valid, chk_addr, chk_machine} = '0;
        chk_kind = ACC_READ;
    end
    // One CSR instruction, the only way to the registers; released address and data go inverse
    task automatic csr(input logic w, input logic [11:0] a, input logic [31:0] d, input logic m);
        @(posedge clock);
        #1 {csr_valid, csr_write, csr_addr, csr_wdata, csr_machine} = {1'b1, w, a, d, m};
        @(posedge clock);
        #1 {csr_valid, csr_addr, csr_wdata} = {1'b0, ~a, ~d};
    endtask
    // One memory access; the verdict stands in the cycle of return
    task automatic chk(input logic [31:0] a, input access_kind_t k, input logic m);
        @(posedge clock);
        #1 chk_kind = k;
        {chk_valid, chk_addr, chk_machine} = {1'b1, a, m};
        @(posedge clock);
        #1 {chk_valid, chk_addr} = {1'b0, ~a};
    endtask
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import mprot_pkg::*;
    logic clock = 1'b0; // Core clock
    logic rst = 1'b1; // Reset
    logic ce = 1'b1; // Enabled except while s_hold drives it low
    logic csr_valid, csr_write, csr_machine, csr_ack, csr_err;
    logic [11:0] csr_addr;
    logic [31:0] csr_wdata, csr_rdata, chk_addr;
    access_kind_t chk_kind;
    logic chk_valid, chk_machine, chk_done, chk_allow, chk_matched, system_exception;
    logic [1:0] chk_entry;
    int err_count = 0;
    int total_checks = 0;
    // Access table: address, and {kind, machine, allow, matched, entry}
    logic [31:0] ta [11] = '{32'h3FC, 32'h400, 32'h0, 32'h800, 32'h804, 32'h1004,
                             32'h1004, 32'h1010, 32'hFFC, 32'h0, 32'h2000};
    logic [7:0] tk [11] = '{8'h2C, 8'h20, 8'h44, 8'h4D, 8'h40, 8'h8E, 8'h26, 8'h2F,
                            8'h80, 8'h5C, 8'h38};
    always #5 clock = ~clock;
    physical_memory_protect_unit u_physical_memory_protect_unit (.*);
    core_model u_core_model (.*);
    task automatic cmp(input logic [39:0] seen, input logic [39:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        u_core_model.csr(1'b1, a, d, 1'b1);
    endtask
    // Read and compare {error, data}
    task automatic rd(input logic [11:0] a, input logic m, input logic [32:0] exp);
        u_core_model.csr(1'b0, a, 32'h0, m);
        cmp({csr_err, csr_rdata}, exp);
    endtask
    // One user or machine access and its full verdict; a refusal must trap
    task automatic chk(input logic [31:0] a, input logic [7:0] t);
        u_core_model.chk(a, access_kind_t'(t[7:5]), t[4]);
        cmp({chk_done, chk_allow, chk_matched, chk_entry, system_exception},
            {1'b1, t[3:0], ~t[3]});
    endtask
    task automatic s_reset();
        rd(12'h3A0, 1'b1, 33'h0);
        for (int i = 0; i < 4; i++) begin
            rd(12'h3B0 + 12'(i), 1'b1, 33'h0);
        end
        chk(32'h0, 8'h20);
    endtask
    // Reserved bits, full bound width, privilege and unmapped numbers
    task automatic s_regs();
        wr(12'h3A0, 32'h6060_6060);
        rd(12'h3A0, 1'b1, 33'h0);
        wr(12'h3B1, 32'hC000_0010);
        u_core_model.csr(1'b1, 12'h3B1, 32'h5, 1'b0);
        rd(12'h3B1, 1'b1, 33'hC000_0010);
        rd(12'h3B1, 1'b0, 33'h1_0000_0000);
        rd(12'h3A1, 1'b1, 33'h1_0000_0000);
    endtask
    // Range, word, power-of-two and overlapping entries; entry 3 bound has bits 31:30 set, which matching ignores
    task automatic s_match();
        wr(12'h3B0, 32'h100);
        wr(12'h3B1, 32'h200);
        wr(12'h3B2, 32'h401);
        wr(12'h3B3, 32'hC000_0500);
        wr(12'h3A0, 32'h0F1C_1209);
        rd(12'h3A0, 1'b1, 33'h0F1C_1209);
        for (int i = 0; i < 11; i++) begin
            chk(ta[i], tk[i]);
        end
    endtask
    // Locked entry binds machine mode and ignores writes; a disabled entry steps aside
    task automatic s_lock();
        wr(12'h3A0, 32'h0F1C_1289);
        chk(32'h0, 8'h54);
        wr(12'h3B0, 32'h50);
        rd(12'h3B0, 1'b1, 33'h100);
        wr(12'h3A0, 32'h0F04_1300);
        rd(12'h3A0, 1'b1, 33'h0F04_1389);
        chk(32'h1004, 8'h8F);
    endtask
    // Enable low: a request is not taken and the last verdict stays put
    task automatic s_hold();
        @(posedge clock);
        #1 ce = 1'b0;
        u_core_model.chk(32'h2000, ACC_READ, 1'b0);
        cmp({chk_done, chk_allow, system_exception}, 3'h2);
        ce = 1'b1;
        @(posedge clock);
        #1 cmp({chk_done, chk_allow, system_exception}, 3'h2);
    endtask
    initial begin
        repeat (4) @(posedge clock);
        #1 rst = 1'b0;
        s_reset();
        s_regs();
        s_match();
        s_lock();
        s_hold();
        stop_test();
    end
endmodule
bind physical_memory_protect_unit pmp_check u_pmp_check (.*);
`default_nettype wire
